// file: hw/aspc_ctrl.v
// amplifier state, protection and soft volume control with a control-port slave
// assumes analog comparators give level fault indications and audio samples
// arrive on the system clock; pins and the sample clock are asynchronous
`include "aspc_map.vh"
`default_nettype none

module aspc_sync #(
	parameter W = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
)(
	input wire clk_i,
	input wire rst_i,
	input wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);
	reg [W-1:0] s1_reg;
	reg [W-1:0] s2_reg;
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_reg <= INIT;
			s2_reg <= INIT;
		end else begin
			s1_reg <= d_i;
			s2_reg <= s1_reg;
		end
	end
	assign q_o = s2_reg;
endmodule // aspc_sync

// Function
// - state field 11 in the power-state register keeps the device playing.
// - state field codes: 00 deep sleep, 01 sleep, 10 hi-Z, 11 play.
// - DC offset persisting over 600ms pulls fault pin low, forces hi-Z, flags 0x70.
// - DC flag and hi-Z hold until software clears through 0x78.
// - over-temperature forces hi-Z and sets the thermal shutdown flag.
// - auto-recovery resumes play on cooling, otherwise only after a fault clear.
// - supply over-voltage forces hi-Z and sets the over-voltage flag.
// - play resumes when over-voltage ends; flag stays until cleared.
// - under-voltage forces hi-Z, sets flag; play resumes, flag held until cleared.
// - writing 1 to bit 0 of the fault-clear register clears latched flags.
// - ramp steps volume once per sample period by 0.5dB.
// - mute bit ramps volume down smoothly; clearing ramps it back up.
// - paralleled bridge drives both pairs from left-frame samples.
// - with sleep on clock fault enabled, a clock fault forces deep sleep.
module aspc_ctrl #(
	parameter [6:0] I2C_ADDR = 7'h4c,
	parameter [7:0] CHIP_ID = 8'h5a, // arbitrary value
	parameter [31:0] DC_PERSIST_CYCLES = `ASPC_DC_PERSIST_MS * (`ASPC_CLK_HZ / 1000)
)(
	input wire SYS_CLK_I,
	input wire RST_I,
	input wire SCL_I,
	input wire SDA_I,
	output wire SDA_O,
	output wire SDA_OE_O,
	input wire POWER_DOWN_N_I,
	input wire LRCLK_I,
	input wire DC_OFFSET_I,
	input wire OVER_TEMP_I,
	input wire TEMP_COOLED_I,
	input wire OVER_VOLT_I,
	input wire UNDER_VOLT_I,
	input wire CLOCK_FAULT_I,
	input wire SAMPLE_VALID_I,
	input wire [23:0] LEFT_SAMPLE_I,
	input wire [23:0] RIGHT_SAMPLE_I,
	output reg [23:0] OUT_A_O,
	output reg [23:0] OUT_B_O,
	output reg [7:0] VOLUME_O,
	output reg [1:0] POWER_STATE_O,
	output reg SHUTDOWN_O,
	output reg OUT_HIZ_O,
	output wire FAULT_O,
	output reg FAULT_OE_O
);
	localparam S_IDLE = 3'h0;
	localparam S_ADDR = 3'h1;
	localparam S_AACK = 3'h2;
	localparam S_WR = 3'h3;
	localparam S_WACK = 3'h4;
	localparam S_RD = 3'h5;
	localparam S_RACK = 3'h6;

	wire [9:0] syn;
	reg scl_d_reg;
	reg sda_d_reg;
	reg lr_d_reg;
	reg ckf_d_reg;
	reg [7:0] regs [0:127];
	reg [2:0] st_reg;
	reg [2:0] cnt_reg;
	reg [7:0] sh_reg;
	reg [6:0] ptr_reg;
	reg first_reg;
	reg rw_reg;
	reg oe_reg;
	reg full_reg;
	reg nack_reg;
	reg wr_reg;
	reg [6:0] wa_reg;
	reg [7:0] wd_reg;
	reg [31:0] dc_cnt_reg;
	reg dc_flag_reg;
	reg ot_flag_reg;
	reg ot_hold_reg;
	reg ov_flag_reg;
	reg uv_flag_reg;
	reg ck_flag_reg;
	reg [7:0] rdata;
	reg [7:0] vol_next;
	integer i;

	aspc_sync #(.W(10), .INIT(10'h003)) u_sync (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.d_i({CLOCK_FAULT_I, UNDER_VOLT_I, OVER_VOLT_I, TEMP_COOLED_I, OVER_TEMP_I,
			DC_OFFSET_I, LRCLK_I, POWER_DOWN_N_I, SDA_I, SCL_I}),
		.q_o(syn)
	);

	wire scl_s = syn[0];
	wire sda_s = syn[1];
	wire pdn_s = syn[2];
	wire lr_s = syn[3];
	wire dc_s = syn[4];
	wire ot_s = syn[5];
	wire cool_s = syn[6];
	wire ov_s = syn[7];
	wire uv_s = syn[8];
	wire ckf_s = syn[9];

	wire scl_rise = scl_s & ~scl_d_reg;
	wire scl_fall = ~scl_s & scl_d_reg;
	wire bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	wire sample_tick = lr_s & ~lr_d_reg;
	wire ckf_rise = ckf_s & ~ckf_d_reg;
	wire page0 = (regs[`ASPC_OFF_PAGE] == 8'h00) && (regs[`ASPC_OFF_BOOK] == 8'h00);

	function is_rw;
		input [6:0] a;
		begin
			case (a)
			`ASPC_OFF_PAGE, `ASPC_OFF_SOFT_RESET, `ASPC_OFF_MODULATION,
			`ASPC_OFF_POWER_STATE, `ASPC_OFF_FAULT_CLEAR_SYNC, `ASPC_OFF_PAGE_INC,
			`ASPC_OFF_SAMPLE_RATE, `ASPC_OFF_CLOCK_CHECK_MASK, `ASPC_OFF_ECHO_OUT,
			`ASPC_OFF_BITCLK_POL, `ASPC_OFF_PORT_FMT1, `ASPC_OFF_PORT_FMT2,
			`ASPC_OFF_PORT_FMT3, `ASPC_OFF_VOLUME, `ASPC_OFF_RAMP_CFG,
			`ASPC_OFF_RAMP_CFG2, `ASPC_OFF_ANALOG_BW, `ASPC_OFF_AMP_GAIN,
			`ASPC_OFF_COEF_WR, `ASPC_OFF_PIN_A, `ASPC_OFF_PIN_B, `ASPC_OFF_PIN_C,
			`ASPC_OFF_PHASE, `ASPC_OFF_SPREAD0, `ASPC_OFF_SPREAD1, `ASPC_OFF_SPREAD2,
			`ASPC_OFF_SPREAD3, `ASPC_OFF_SPREAD4, `ASPC_OFF_PIN_CFG1,
			`ASPC_OFF_PIN_CFG2, `ASPC_OFF_MISC, `ASPC_OFF_BOOK: is_rw = 1'b1;
			default: is_rw = 1'b0;
			endcase
		end
	endfunction

	function [7:0] rst_val;
		input [6:0] a;
		begin
			case (a)
			`ASPC_OFF_POWER_STATE: rst_val = `ASPC_RST_POWER_STATE;
			`ASPC_OFF_PORT_FMT1: rst_val = `ASPC_RST_PORT_FMT1;
			default: rst_val = `ASPC_RST_DEFAULT;
			endcase
		end
	endfunction

	// write-only and self-clearing bits are never stored
	function [7:0] keep_mask;
		input [6:0] a;
		begin
			case (a)
			`ASPC_OFF_SOFT_RESET: keep_mask = `ASPC_MASK_SOFT_RESET;
			`ASPC_OFF_FAULT_CLEAR_SYNC: keep_mask = `ASPC_MASK_FAULT_CLEAR_SYNC;
			default: keep_mask = 8'hff;
			endcase
		end
	endfunction

	wire acc_ok = page0 || (wa_reg == `ASPC_OFF_PAGE) || (wa_reg == `ASPC_OFF_BOOK);
	// unmapped offsets drop writes, so reserved locations cannot be disturbed
	wire wr_ok = wr_reg && acc_ok && is_rw(wa_reg);
	wire soft_rst = wr_ok && (wa_reg == `ASPC_OFF_SOFT_RESET) &&
		wd_reg[`ASPC_BIT_SOFT_RESET_REGS];
	wire fault_clr = wr_reg && page0 && wd_reg[`ASPC_BIT_CLEAR_FAULT] &&
		((wa_reg == `ASPC_OFF_FAULT_CLEAR) || (wa_reg == `ASPC_OFF_FAULT_CLEAR_SYNC));
	wire [7:0] pwr = regs[`ASPC_OFF_POWER_STATE];
	wire [1:0] req_state = pwr[1:0];
	wire ot_auto = regs[`ASPC_OFF_MISC][`ASPC_BIT_OT_AUTO_RECOVER];
	wire hiz_force = dc_flag_reg | ot_hold_reg | ov_s | uv_s;
	wire play = pdn_s && (req_state == `ASPC_ST_PLAY) && !hiz_force;
	wire bridge_par = regs[`ASPC_OFF_MODULATION][`ASPC_BIT_BRIDGE_PARALLEL];
	// a requested state other than play also ramps the volume down, while hi-Z follows at once
	wire vol_down = pwr[`ASPC_BIT_MUTE] || (req_state != `ASPC_ST_PLAY);
	wire [7:0] vol_target = vol_down ? `ASPC_VOL_MUTED : regs[`ASPC_OFF_VOLUME];

	always @* begin
		rdata = 8'h00;
		if (page0 || ptr_reg == `ASPC_OFF_PAGE || ptr_reg == `ASPC_OFF_BOOK) begin
			case (ptr_reg)
			`ASPC_OFF_CHANNEL_FAULT_FLAGS: rdata[`ASPC_BIT_DC_FAULT] = dc_flag_reg;
			`ASPC_OFF_SUPPLY_FAULT: rdata = {5'h00, ck_flag_reg, ov_flag_reg, uv_flag_reg};
			`ASPC_OFF_THERMAL_FAULT: rdata[`ASPC_BIT_OT_FAULT] = ot_flag_reg;
			`ASPC_OFF_CLOCK_RESULT: rdata[`ASPC_BIT_CLOCK_FAULT] = ckf_s;
			`ASPC_OFF_CHIP_ID: rdata = CHIP_ID;
			`ASPC_OFF_FAULT_CLEAR: rdata = 8'h00;
			default: rdata = regs[ptr_reg];
			endcase
		end
	end

	always @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			lr_d_reg <= 1'b0;
			ckf_d_reg <= 1'b0;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
			lr_d_reg <= lr_s;
			ckf_d_reg <= ckf_s;
		end
	end

	// control-port slave: bits taken on SCL rise, SDA changed after SCL fall
	always @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			st_reg <= S_IDLE;
			cnt_reg <= 3'h0;
			sh_reg <= 8'h00;
			ptr_reg <= 7'h00;
			first_reg <= 1'b0;
			rw_reg <= 1'b0;
			oe_reg <= 1'b0;
			full_reg <= 1'b0;
			nack_reg <= 1'b0;
			wr_reg <= 1'b0;
			wa_reg <= 7'h00;
			wd_reg <= 8'h00;
		end else begin
			wr_reg <= 1'b0;
			if (bus_start) begin
				st_reg <= S_ADDR;
				cnt_reg <= 3'h0;
				full_reg <= 1'b0;
				first_reg <= 1'b1;
				oe_reg <= 1'b0;
			end else if (bus_stop) begin
				st_reg <= S_IDLE;
				oe_reg <= 1'b0;
			end else begin
				case (st_reg)
				S_ADDR, S_WR: begin
					if (scl_rise) begin
						sh_reg <= {sh_reg[6:0], sda_s};
						cnt_reg <= cnt_reg + 3'h1;
						full_reg <= (cnt_reg == 3'h7);
					end else if (scl_fall && full_reg) begin
						full_reg <= 1'b0;
						if (st_reg == S_ADDR) begin
							if (sh_reg[7:1] == I2C_ADDR) begin
								rw_reg <= sh_reg[0];
								oe_reg <= 1'b1;
								st_reg <= S_AACK;
							end else begin
								st_reg <= S_IDLE;
							end
						end else begin
							oe_reg <= 1'b1;
							st_reg <= S_WACK;
							first_reg <= 1'b0;
							if (first_reg) begin
								ptr_reg <= sh_reg[6:0];
							end else begin
								wr_reg <= 1'b1;
								wa_reg <= ptr_reg;
								wd_reg <= sh_reg;
								ptr_reg <= ptr_reg + 7'h01;
							end
						end
					end
				end
				S_AACK, S_WACK: begin
					if (scl_fall) begin
						cnt_reg <= 3'h0;
						if (st_reg == S_AACK && rw_reg) begin
							sh_reg <= rdata;
							oe_reg <= ~rdata[7];
							st_reg <= S_RD;
						end else begin
							oe_reg <= 1'b0;
							st_reg <= S_WR;
						end
					end
				end
				S_RD: begin
					if (scl_rise) begin
						cnt_reg <= cnt_reg + 3'h1;
						full_reg <= (cnt_reg == 3'h7);
					end else if (scl_fall) begin
						if (full_reg) begin
							full_reg <= 1'b0;
							oe_reg <= 1'b0;
							ptr_reg <= ptr_reg + 7'h01;
							st_reg <= S_RACK;
						end else begin
							sh_reg <= {sh_reg[6:0], 1'b0};
							oe_reg <= ~sh_reg[6];
						end
					end
				end
				S_RACK: begin
					if (scl_rise) begin
						nack_reg <= sda_s;
					end else if (scl_fall) begin
						if (!nack_reg) begin
							sh_reg <= rdata;
							oe_reg <= ~rdata[7];
							cnt_reg <= 3'h0;
							st_reg <= S_RD;
						end else begin
							st_reg <= S_IDLE;
						end
					end
				end
				default: st_reg <= S_IDLE;
				endcase
			end
		end
	end

	assign SDA_O = 1'b0;
	assign SDA_OE_O = oe_reg;
	assign FAULT_O = 1'b0;

	always @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			for (i = 0; i < 128; i = i + 1)
				regs[i] <= rst_val(i[6:0]);
		end else begin
			if (soft_rst) begin
				for (i = 0; i < 128; i = i + 1)
					regs[i] <= rst_val(i[6:0]);
			end else if (wr_ok) begin
				regs[wa_reg] <= wd_reg & keep_mask(wa_reg);
			end
			// hardware wins over a software write in the same cycle
			if (ckf_rise && pwr[`ASPC_BIT_SLEEP_ON_CLOCK_FAULT])
				regs[`ASPC_OFF_POWER_STATE][1:0] <= `ASPC_ST_DEEP_SLEEP;
		end
	end

	// fault flags: a live fault condition wins over a clear in the same cycle
	always @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			dc_cnt_reg <= 32'h0;
			dc_flag_reg <= 1'b0;
			ot_flag_reg <= 1'b0;
			ot_hold_reg <= 1'b0;
			ov_flag_reg <= 1'b0;
			uv_flag_reg <= 1'b0;
			ck_flag_reg <= 1'b0;
		end else begin
			if (!dc_s)
				dc_cnt_reg <= 32'h0;
			else if (dc_cnt_reg < DC_PERSIST_CYCLES)
				dc_cnt_reg <= dc_cnt_reg + 32'h1;
			if (dc_s && dc_cnt_reg >= DC_PERSIST_CYCLES)
				dc_flag_reg <= 1'b1;
			else if (fault_clr)
				dc_flag_reg <= 1'b0;
			if (ot_s)
				ot_flag_reg <= 1'b1;
			else if (fault_clr)
				ot_flag_reg <= 1'b0;
			if (ot_s)
				ot_hold_reg <= 1'b1;
			else if ((ot_auto && cool_s) || (!ot_auto && fault_clr))
				ot_hold_reg <= 1'b0;
			if (ov_s)
				ov_flag_reg <= 1'b1;
			else if (fault_clr)
				ov_flag_reg <= 1'b0;
			if (uv_s)
				uv_flag_reg <= 1'b1;
			else if (fault_clr)
				uv_flag_reg <= 1'b0;
			if (ckf_s)
				ck_flag_reg <= 1'b1;
			else if (fault_clr)
				ck_flag_reg <= 1'b0;
		end
	end

	// one attenuation code is 0.5dB; 0xff is treated as full mute
	always @* begin
		vol_next = VOLUME_O;
		if (sample_tick) begin
			if (VOLUME_O < vol_target)
				vol_next = VOLUME_O + 8'h01;
			else if (VOLUME_O > vol_target)
				vol_next = VOLUME_O - 8'h01;
		end
	end

	always @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			VOLUME_O <= `ASPC_VOL_MUTED;
			OUT_A_O <= 24'h000000;
			OUT_B_O <= 24'h000000;
			POWER_STATE_O <= `ASPC_ST_DEEP_SLEEP;
			SHUTDOWN_O <= 1'b1;
			OUT_HIZ_O <= 1'b1;
			FAULT_OE_O <= 1'b0;
		end else begin
			VOLUME_O <= vol_next;
			POWER_STATE_O <= req_state;
			SHUTDOWN_O <= ~pdn_s;
			OUT_HIZ_O <= ~play;
			FAULT_OE_O <= dc_flag_reg;
			if (SAMPLE_VALID_I) begin
				if (!play || VOLUME_O == `ASPC_VOL_MUTED) begin
					OUT_A_O <= 24'h000000;
					OUT_B_O <= 24'h000000;
				end else begin
					OUT_A_O <= LEFT_SAMPLE_I;
					OUT_B_O <= bridge_par ? LEFT_SAMPLE_I : RIGHT_SAMPLE_I;
				end
			end
		end
	end
endmodule // aspc_ctrl
`default_nettype wire

// file: hw/aspc_map.vh
// register offsets, field positions, reset values and timing counts
// assumes a 50 MHz system clock and 7-bit register offsets in book 0, page 0
`ifndef ASPC_MAP_VH
`define ASPC_MAP_VH
`define ASPC_CLK_HZ 50000000
`define ASPC_DC_PERSIST_MS 600
`define ASPC_OFF_PAGE 7'h00
`define ASPC_OFF_SOFT_RESET 7'h01
`define ASPC_OFF_MODULATION 7'h02
`define ASPC_OFF_POWER_STATE 7'h03
`define ASPC_OFF_FAULT_CLEAR_SYNC 7'h0d
`define ASPC_OFF_PAGE_INC 7'h0f
`define ASPC_OFF_SAMPLE_RATE 7'h28
`define ASPC_OFF_CLOCK_CHECK_MASK 7'h29
`define ASPC_OFF_ECHO_OUT 7'h30
`define ASPC_OFF_BITCLK_POL 7'h31
`define ASPC_OFF_PORT_FMT1 7'h33
`define ASPC_OFF_PORT_FMT2 7'h34
`define ASPC_OFF_PORT_FMT3 7'h35
`define ASPC_OFF_RATE_MON 7'h37
`define ASPC_OFF_BITCLK_MON 7'h38
`define ASPC_OFF_CLOCK_RESULT 7'h39
`define ASPC_OFF_VOLUME 7'h4c
`define ASPC_OFF_RAMP_CFG 7'h4e
`define ASPC_OFF_RAMP_CFG2 7'h4f
`define ASPC_OFF_ANALOG_BW 7'h53
`define ASPC_OFF_AMP_GAIN 7'h54
`define ASPC_OFF_COEF_WR 7'h5c
`define ASPC_OFF_PIN_A 7'h62
`define ASPC_OFF_PIN_B 7'h63
`define ASPC_OFF_PIN_C 7'h64
`define ASPC_OFF_CHIP_ID 7'h67
`define ASPC_OFF_PHASE 7'h6a
`define ASPC_OFF_SPREAD0 7'h6b
`define ASPC_OFF_SPREAD1 7'h6c
`define ASPC_OFF_SPREAD2 7'h6d
`define ASPC_OFF_SPREAD3 7'h6e
`define ASPC_OFF_SPREAD4 7'h6f
`define ASPC_OFF_CHANNEL_FAULT_FLAGS 7'h70
`define ASPC_OFF_SUPPLY_FAULT 7'h71
`define ASPC_OFF_THERMAL_FAULT 7'h72
`define ASPC_OFF_THERMAL_WARN 7'h73
`define ASPC_OFF_PIN_CFG1 7'h74
`define ASPC_OFF_PIN_CFG2 7'h75
`define ASPC_OFF_MISC 7'h76
`define ASPC_OFF_FAULT_CLEAR 7'h78
`define ASPC_OFF_BOOK 7'h7f
`define ASPC_RST_POWER_STATE 8'h10
`define ASPC_RST_PORT_FMT1 8'h02
`define ASPC_RST_DEFAULT 8'h00
`define ASPC_MASK_SOFT_RESET 8'he0
`define ASPC_MASK_FAULT_CLEAR_SYNC 8'hfe
`define ASPC_BIT_SOFT_RESET_REGS 0
`define ASPC_BIT_BRIDGE_PARALLEL 2
`define ASPC_BIT_MUTE 3
`define ASPC_BIT_SLEEP_ON_CLOCK_FAULT 6
`define ASPC_BIT_CLEAR_FAULT 0
`define ASPC_BIT_OT_AUTO_RECOVER 0
`define ASPC_BIT_DC_FAULT 2
`define ASPC_BIT_UV_FAULT 0
`define ASPC_BIT_OV_FAULT 1
`define ASPC_BIT_CLOCK_FAULT 2
`define ASPC_BIT_OT_FAULT 0
`define ASPC_ST_DEEP_SLEEP 2'h0
`define ASPC_ST_SLEEP 2'h1
`define ASPC_ST_HIZ 2'h2
`define ASPC_ST_PLAY 2'h3
`define ASPC_VOL_MUTED 8'hff
`endif

// file: verification/aspc_ctrl_monitor.sv
// assertion checker for the amplifier state and protection control block
// assumes only the top-level ports; the persistence count follows the bound instance
`default_nettype none
module aspc_ctrl_monitor #(
	parameter [31:0] DC_PERSIST_CYCLES = 32'd20
)(
	input wire SYS_CLK_I,
	input wire RST_I,
	input wire POWER_DOWN_N_I,
	input wire DC_OFFSET_I,
	input wire OVER_TEMP_I,
	input wire OVER_VOLT_I,
	input wire UNDER_VOLT_I,
	input wire SAMPLE_VALID_I,
	input wire [23:0] LEFT_SAMPLE_I,
	input wire [23:0] OUT_A_O,
	input wire [23:0] OUT_B_O,
	input wire [7:0] VOLUME_O,
	input wire [1:0] POWER_STATE_O,
	input wire SHUTDOWN_O,
	input wire OUT_HIZ_O,
	input wire FAULT_OE_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);
	// raw count of offset-high cycles; the synchroniser only adds to it
	logic [31:0] dc_hi_reg;
	always @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I)
			dc_hi_reg <= 32'h0;
		else
			dc_hi_reg <= DC_OFFSET_I ? dc_hi_reg + 32'h1 : 32'h0;
	end
	dc_early_a: assert property ($rose(FAULT_OE_O) |-> dc_hi_reg >= DC_PERSIST_CYCLES)
		else $error("fault pin pulled before the offset persisted");
	dc_late_a: assert property (dc_hi_reg == DC_PERSIST_CYCLES + 32'd8 |-> FAULT_OE_O)
		else $error("fault pin not pulled after persistent offset");
	fault_hiz_a: assert property (FAULT_OE_O && $past(FAULT_OE_O) |-> OUT_HIZ_O)
		else $error("outputs left driven during a latched offset fault");
	hiz_state_a: assert property (POWER_STATE_O != 2'h3 &&
		$past(POWER_STATE_O) != 2'h3 |-> OUT_HIZ_O)
		else $error("outputs driven outside the play state");
	live_hiz_a: assert property (
		(OVER_VOLT_I || UNDER_VOLT_I || OVER_TEMP_I) [*5] |-> OUT_HIZ_O)
		else $error("outputs driven during a supply or thermal fault");
	pdn_off_a: assert property (!POWER_DOWN_N_I [*5] |-> SHUTDOWN_O)
		else $error("shutdown not shown while power-down pin low");
	vol_step_a: assert property ($changed(VOLUME_O) |->
		VOLUME_O == $past(VOLUME_O) + 8'h01 || VOLUME_O == $past(VOLUME_O) - 8'h01)
		else $error("volume moved by more than one step");
	vol_rate_a: assert property ($changed(VOLUME_O) |=> $stable(VOLUME_O) [*3])
		else $error("volume stepped twice within one frame");
	left_out_a: assert property ($past(SAMPLE_VALID_I) && !OUT_HIZ_O &&
		!$past(OUT_HIZ_O) && VOLUME_O != 8'hff && $past(VOLUME_O) != 8'hff |->
		OUT_A_O == $past(LEFT_SAMPLE_I))
		else $error("first pair does not carry the left sample");
	mute_quiet_a: assert property ($past(SAMPLE_VALID_I) && VOLUME_O == 8'hff &&
		$past(VOLUME_O) == 8'hff |-> OUT_A_O == 24'h0 && OUT_B_O == 24'h0)
		else $error("audio passed while fully muted");
endmodule // aspc_ctrl_monitor
bind aspc_ctrl aspc_ctrl_monitor #(.DC_PERSIST_CYCLES(DC_PERSIST_CYCLES)) aspc_ctrl_monitor_i (
	.SYS_CLK_I, .RST_I, .POWER_DOWN_N_I, .DC_OFFSET_I, .OVER_TEMP_I, .OVER_VOLT_I,
	.UNDER_VOLT_I, .SAMPLE_VALID_I, .LEFT_SAMPLE_I, .OUT_A_O, .OUT_B_O, .VOLUME_O,
	.POWER_STATE_O, .SHUTDOWN_O, .OUT_HIZ_O, .FAULT_OE_O);
`default_nettype wire

// file: verification/aspc_host_model.sv
// control-port host model: start, stop and byte transfers, pointer write then data
// assumes the bench resolves the open-drain data line with a pull-up
`default_nettype none
module aspc_host_model #(
	parameter [6:0] ADDR = 7'h4c
)(
	output logic scl_o,
	output logic sda_oe_o,
	input wire logic sda_i
);
	timeunit 1ns;
	timeprecision 1ns;
	// half of the low phase, and the high phase; both stay inside fast mode
	// multiples of the system period so tasks return on the bench's stimulus phase
	localparam int L = 660;
	localparam int H = 620;
	logic ack = 1'b0;
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	task automatic put(input logic b);
		sda_oe_o = ~b;
		#L scl_o = 1'b1;
		#H scl_o = 1'b0;
		#L;
	endtask
	task automatic get(output logic b);
		sda_oe_o = 1'b0;
		#L scl_o = 1'b1;
		#(H/2) b = sda_i;
		#(H/2) scl_o = 1'b0;
		#L;
	endtask
	task automatic start;
		sda_oe_o = 1'b0;
		#L scl_o = 1'b1;
		#H sda_oe_o = 1'b1;
		#H scl_o = 1'b0;
		#L;
	endtask
	task automatic stop;
		sda_oe_o = 1'b1;
		#L scl_o = 1'b1;
		#H sda_oe_o = 1'b0;
		#(2*L);
	endtask
	task automatic send(input logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--)
			put(d[i]);
		get(a);
		ack = ~a;
	endtask
	// only mapped offsets are ever written
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		start;
		send({ADDR, 1'b0});
		send(p);
		send(d);
		stop;
	endtask
	task automatic rd(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] d);
		start;
		send({ADDR, 1'b0});
		send(p);
		start;
		send({dev, 1'b1});
		for (int i = 7; i >= 0; i--)
			get(d[i]);
		put(1'b1);
		stop;
	endtask
endmodule // aspc_host_model
`default_nettype wire

// file: verification/aspc_ctrl_tb_top.sv
// bench for the amplifier state and protection control block
// assumes the host model for register traffic; fault and audio pins driven directly
`default_nettype none
module aspc_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam [7:0] ID = 8'h3c; // arbitrary value
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic pdn_n = 1'b1;
	logic lrclk = 1'b0;
	logic dc = 1'b0, ot = 1'b0, cool = 1'b1, ov = 1'b0, uv = 1'b0, ckf = 1'b0, sv = 1'b0;
	logic [23:0] lsamp = 24'h0, rsamp = 24'h0;
	logic scl, host_oe;
	wire sda_oe, shd, hiz, foe;
	wire sda = ~(host_oe | sda_oe);
	wire [23:0] out_a, out_b;
	wire [7:0] vol;
	wire [1:0] pst;
	int mismatches = 0;
	int cmp_count = 0;
	logic [7:0] rv;
	always #10 clk = ~clk;
	initial begin
		#7;
		forever #80 lrclk = ~lrclk;
	end
	aspc_host_model aspc_host_model_i (.scl_o(scl), .sda_oe_o(host_oe), .sda_i(sda));
	aspc_ctrl #(.CHIP_ID(ID), .DC_PERSIST_CYCLES(32'd20)) aspc_ctrl_i (
		.SYS_CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(), .SDA_OE_O(sda_oe),
		.POWER_DOWN_N_I(pdn_n), .LRCLK_I(lrclk), .DC_OFFSET_I(dc), .OVER_TEMP_I(ot),
		.TEMP_COOLED_I(cool), .OVER_VOLT_I(ov), .UNDER_VOLT_I(uv), .CLOCK_FAULT_I(ckf),
		.SAMPLE_VALID_I(sv), .LEFT_SAMPLE_I(lsamp), .RIGHT_SAMPLE_I(rsamp), .OUT_A_O(out_a),
		.OUT_B_O(out_b), .VOLUME_O(vol), .POWER_STATE_O(pst), .SHUTDOWN_O(shd),
		.OUT_HIZ_O(hiz), .FAULT_O(), .FAULT_OE_O(foe));
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic rchk(input logic [7:0] p, input logic [7:0] e);
		aspc_host_model_i.rd(7'h4c, p, rv);
		check($sformatf("register %h", p), e, rv);
	endtask
	task automatic ramp_to(input logic [7:0] v);
		for (int i = 0; i < 300 && vol !== v; i++)
			tick(8);
		check("volume", v, vol);
	endtask
	task automatic sample(input logic [23:0] l, input logic [23:0] r);
		lsamp = l;
		rsamp = r;
		sv = 1'b1;
		tick(1);
		sv = 1'b0;
		tick(2);
	endtask
	task automatic hiz_after(input int n, input logic e);
		tick(n);
		check("hi-z", e, hiz);
	endtask
	initial begin
		// register traffic dominates; a clean run ends a little before 2 ms
		#2400us;
		mismatches++;
		close_out;
	end
	initial begin
		tick(5);
		rst = 1'b0;
		tick(5);
		check("state", 2'h0, pst);
		rchk(8'h03, 8'h10);
		rchk(8'h33, 8'h02);
		rchk(8'h67, ID);
		rchk(8'h05, 8'h00);
		aspc_host_model_i.rd(7'h4d, 8'h03, rv);
		check("foreign address ack", 1'b0, aspc_host_model_i.ack);
		// the play volume comes from the volume register, which resets to zero
		aspc_host_model_i.wr(8'h4c, 8'h4c);
		for (int s = 0; s < 4; s++) begin
			aspc_host_model_i.wr(8'h03, 8'(s));
			check("state", s[1:0], pst);
			hiz_after(2, s != 3);
		end
		ramp_to(8'h4c);
		sample(24'h123456, 24'h0abcde);
		check("pair a", 24'h123456, out_a);
		check("pair b", 24'h0abcde, out_b);
		aspc_host_model_i.wr(8'h02, 8'h04);
		sample(24'h654321, 24'h0fedcb);
		check("parallel b", 24'h654321, out_b);
		aspc_host_model_i.wr(8'h02, 8'h00);
		aspc_host_model_i.wr(8'h03, 8'h0b);
		check("ramping", 1'b1, vol > 8'h4c && vol < 8'hff);
		ramp_to(8'hff);
		sample(24'h111111, 24'h222222);
		check("muted a", 24'h0, out_a);
		aspc_host_model_i.wr(8'h03, 8'h03);
		ramp_to(8'h4c);
		dc = 1'b1;
		tick(40);
		dc = 1'b0;
		tick(4);
		check("fault pin", 1'b1, foe);
		rchk(8'h70, 8'h04);
		hiz_after(1, 1'b1);
		aspc_host_model_i.wr(8'h78, 8'h01);
		check("fault pin", 1'b0, foe);
		rchk(8'h70, 8'h00);
		for (int m = 0; m < 2; m++) begin
			aspc_host_model_i.wr(8'h76, 8'(m));
			ot = 1'b1;
			cool = 1'b0;
			hiz_after(8, 1'b1);
			ot = 1'b0;
			cool = 1'b1;
			hiz_after(8, m == 0);
			rchk(8'h72, 8'h01);
			aspc_host_model_i.wr(8'h78, 8'h01);
			hiz_after(2, 1'b0);
		end
		ov = 1'b1;
		hiz_after(8, 1'b1);
		ov = 1'b0;
		hiz_after(8, 1'b0);
		rchk(8'h71, 8'h02);
		aspc_host_model_i.wr(8'h78, 8'h01);
		uv = 1'b1;
		hiz_after(8, 1'b1);
		uv = 1'b0;
		hiz_after(8, 1'b0);
		rchk(8'h71, 8'h01);
		aspc_host_model_i.wr(8'h0d, 8'h01);
		rchk(8'h71, 8'h00);
		aspc_host_model_i.wr(8'h03, 8'h43);
		ckf = 1'b1;
		tick(8);
		check("state", 2'h0, pst);
		ckf = 1'b0;
		// output stage is already off, so the pin may now drop
		pdn_n = 1'b0;
		tick(8);
		check("shutdown", 1'b1, shd);
		close_out;
	end
endmodule // aspc_ctrl_tb_top
`default_nettype wire
